// ### include/chan_route_pkg.sv
/*
 * constants and carrier types for the channel routing and sleep block.
 * assumes a 32-bit apb bus with register index = byte address / 4.
 */
package chan_route_pkg;
	localparam int ADDR_W = 12;
	localparam int WORD_W = 16;
	localparam int LANES = 4;
	localparam int FIFO_DEPTH = 16;

	// register indices; byte address is four times the index
	localparam logic [9:0] IDX_RSVD_A = 10'h021;
	localparam logic [9:0] IDX_XBAR = 10'h022;
	localparam logic [9:0] IDX_SLEEP = 10'h023;
	localparam logic [9:0] IDX_DELAY = 10'h024;
	localparam logic [9:0] IDX_STATUS = 10'h03e;
	localparam logic [9:0] IDX_SWPD = 10'h03f;

	localparam logic [15:0] RST_XBAR = 16'h1b1b;
	localparam logic [15:0] RST_SLEEP = 16'hffff;
	localparam logic [15:0] RST_DELAY = 16'h0000;
	localparam logic [15:0] RST_SWPD = 16'h0000;

	// lane pick for lane i sits at 15-2i, output pick for output i at 7-2i
	localparam int LANE_PICK_TOP = 15;
	localparam int OUT_PICK_TOP = 7;

	// sleep field: 15..12 converters, 11 clock rx, 10 pll, 9 lvds data,
	// 8 lvds control, 7 temp sensor, 6 reserved, 5 bias amplifier
	localparam int SLP_CONV_A = 15;
	localparam int SLP_LVDS_DATA = 9;
	localparam int SLP_RSVD = 6;
	localparam logic [15:0] SLEEP_USED = 16'hffa0;

	localparam int DATA_DLY_LSB = 13;
	localparam int CLK_DLY_LSB = 10;
	localparam int DLY_W = 3;
	localparam int DLY_STEP_PS = 40;
	// delay bits 9:0 are not stored
	localparam logic [15:0] DELAY_USED = 16'hfc00;

	localparam int STAT_SLEEP_BIT = 8;

	typedef struct packed {
		logic [LANES-1:0][WORD_W-1:0] word;
	} quad_t;
endpackage

// ### hw/channel_routing_sleep_regs.sv
/*
 * routing crossbar, pin sleep gating and receiver delay registers,
 * with an apb slave and a word fifo in front of the crossbar.
 * assumes one clock sys_clk, async active-high rst, sleepPin asynchronous.
 */
`timescale 1ns/10ps

module quad_word_fifo #(
	parameter int WIDTH = 64,
	parameter int DEPTH = 16
) (
	input wire logic clk, // clock
	input wire logic rst, // async reset
	input wire logic ce, // clock enable
	input wire logic inValid, // write request
	output logic inReady, // space available
	input wire logic [WIDTH-1:0] inData, // write word
	output logic outValid, // word available
	input wire logic outReady, // consumer takes word
	output logic [WIDTH-1:0] outData, // head word
	output logic [$clog2(DEPTH):0] level // words held
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wrPtr_reg;
	logic [AW:0] rdPtr_reg;
	wire doWrite = ce && inValid && inReady;
	wire doRead = ce && outValid && outReady;
	wire full = (wrPtr_reg[AW] != rdPtr_reg[AW]) &&
		(wrPtr_reg[AW-1:0] == rdPtr_reg[AW-1:0]);
	wire empty = wrPtr_reg == rdPtr_reg;

	assign inReady = !full;
	assign outValid = !empty;
	assign outData = mem[rdPtr_reg[AW-1:0]];
	assign level = wrPtr_reg - rdPtr_reg;

	always_ff @(posedge clk) begin
		if (doWrite) begin
			mem[wrPtr_reg[AW-1:0]] <= inData;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
		end else begin
			if (doWrite) wrPtr_reg <= wrPtr_reg + 1'b1;
			if (doRead) rdPtr_reg <= rdPtr_reg + 1'b1;
		end
	end
endmodule

// What this block does
// (R1) Each lane picks one of four input words by two bits, reset 0,1,2,3.
// (R2) Each of the four outputs has a two-bit pick of lane word in bits 7:0.
// (R3) A block sleeps by pin only while the pin is high and its bit is set.
// (R4) Bits 9,8,7,5 gate lvds data and control, temp sensor, bias; 6 is inert.
// (R5) Software sleep bits put the same blocks to sleep alongside the pin.
// (R6) Bits 15:13 of the delay register set the data receiver delay, reset 0.
// (R7) Bits 12:10 of the delay register set the data clock delay, reset zero.
// (R8) Software leaves the first register and delay bits 9:0 at zero.
module channel_routing_sleep_regs #(
	parameter int FIFO_DEPTH = chan_route_pkg::FIFO_DEPTH
) (
	input wire logic sys_clk, // system clock
	input wire logic rst, // async reset, active high
	input wire logic ce, // clock enable, freezes state when low
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [chan_route_pkg::ADDR_W-1:0] paddr, // apb address
	input wire logic [31:0] pwdata, // apb write data
	input wire logic [3:0] pstrb, // apb byte strobes
	output logic pready, // apb ready
	output logic [31:0] prdata, // apb read data
	output logic pslverr, // unmapped address
	input wire logic inValid, // input word group valid
	output logic inReady, // fifo has room
	input wire chan_route_pkg::quad_t inWords, // four input words
	output logic outValid, // routed group valid
	input wire logic outReady, // consumer takes group
	output chan_route_pkg::quad_t outWords, // words to outputs a..d
	input wire logic sleepPin, // external sleep pin
	output logic [15:0] powerDown, // per sub-block power down
	output logic [2:0] dataDelay, // lvds data delay steps
	output logic [2:0] clockDelay // lvds clock delay steps
);
	logic [15:0] xbar_reg;
	logic [15:0] sleepRoute_reg;
	logic [15:0] delay_reg;
	logic [15:0] swPd_reg;
	logic [2:0] sleepSync_reg;
	logic sleepLevel_reg;
	logic [15:0] powerDown_reg;
	logic ready_reg;
	logic [31:0] rdata_reg;
	logic slvErr_reg;
	logic outValid_reg;
	chan_route_pkg::quad_t outWords_reg;
	chan_route_pkg::quad_t fifoWords;
	chan_route_pkg::quad_t laneWords;
	chan_route_pkg::quad_t routedWords;
	logic fifoValid;
	logic [$clog2(FIFO_DEPTH):0] fifoLevel;
	logic loadOut;

	// apb decode
	wire [9:0] regIdx = paddr[chan_route_pkg::ADDR_W-1:2];
	wire selXbar = regIdx == chan_route_pkg::IDX_XBAR;
	wire selSleep = regIdx == chan_route_pkg::IDX_SLEEP;
	wire selDelay = regIdx == chan_route_pkg::IDX_DELAY;
	wire selRsvd = regIdx == chan_route_pkg::IDX_RSVD_A;
	wire selStatus = regIdx == chan_route_pkg::IDX_STATUS;
	wire selSwPd = regIdx == chan_route_pkg::IDX_SWPD;
	wire mapped = selXbar | selSleep | selDelay | selRsvd | selStatus |
		selSwPd;
	wire accessFirst = psel && penable && !ready_reg;
	wire accessDone = psel && penable && ready_reg;
	wire wrAcc = ce && accessDone && pwrite && mapped;
	wire [15:0] laneMask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
	wire [15:0] wrData = pwdata[15:0];

	wire [15:0] statusWord = {7'h00, sleepLevel_reg,
		3'h0, 5'(fifoLevel)};
	wire [15:0] readWord = selXbar ? xbar_reg :
		selSleep ? sleepRoute_reg :
		selDelay ? delay_reg :
		selStatus ? statusWord :
		selSwPd ? swPd_reg : 16'h0000;

	// field merge with byte strobes; delay keeps only its live bits
	wire [15:0] xbarNext = (xbar_reg & ~laneMask) | (wrData & laneMask);
	wire [15:0] sleepNext = (sleepRoute_reg & ~laneMask) |
		(wrData & laneMask);
	wire [15:0] swPdNext = (swPd_reg & ~laneMask) | (wrData & laneMask);
	wire [15:0] delayNext = ((delay_reg & ~laneMask) |
		(wrData & laneMask)) & chan_route_pkg::DELAY_USED;

	assign pready = ready_reg;
	assign prdata = rdata_reg;
	assign pslverr = ready_reg && slvErr_reg;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ready_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			slvErr_reg <= 1'b0;
		end else if (ce) begin
			ready_reg <= accessFirst;
			if (accessFirst) begin
				rdata_reg <= pwrite ? 32'h0000_0000 : {16'h0000, readWord};
				slvErr_reg <= !mapped;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			xbar_reg <= chan_route_pkg::RST_XBAR; // R1 R2
			sleepRoute_reg <= chan_route_pkg::RST_SLEEP;
			delay_reg <= chan_route_pkg::RST_DELAY; // R6 R7
			swPd_reg <= chan_route_pkg::RST_SWPD;
		end else if (wrAcc) begin
			if (selXbar) xbar_reg <= xbarNext; // R1 R2
			if (selSleep) sleepRoute_reg <= sleepNext; // R3
			if (selDelay) delay_reg <= delayNext; // R6 R7 R8
			if (selSwPd) swPd_reg <= swPdNext; // R5
		end
	end

	assign dataDelay = delay_reg[chan_route_pkg::DATA_DLY_LSB +: 3]; // R6
	assign clockDelay = delay_reg[chan_route_pkg::CLK_DLY_LSB +: 3]; // R7

	// sleep pin: three stages, accept a change once stages two and three agree
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sleepSync_reg <= 3'h0;
			sleepLevel_reg <= 1'b0;
			powerDown_reg <= 16'h0000;
		end else if (ce) begin
			sleepSync_reg <= {sleepSync_reg[1:0], sleepPin};
			if (sleepSync_reg[1] == sleepSync_reg[2]) begin
				sleepLevel_reg <= sleepSync_reg[2];
			end
			powerDown_reg <= (({16{sleepLevel_reg}} & sleepRoute_reg) |
				swPd_reg) & chan_route_pkg::SLEEP_USED; // R3 R4 R5
		end
	end
	assign powerDown = powerDown_reg;

	quad_word_fifo #(
		.WIDTH($bits(chan_route_pkg::quad_t)),
		.DEPTH(FIFO_DEPTH)
	) wordFifo (
		.clk(sys_clk),
		.rst(rst),
		.ce(ce),
		.inValid(inValid),
		.inReady(inReady),
		.inData(inWords),
		.outValid(fifoValid),
		.outReady(loadOut),
		.outData(fifoWords),
		.level(fifoLevel)
	);

	// two-stage crossbar: input word to lane, lane word to output
	for (genvar i = 0; i < chan_route_pkg::LANES; i++) begin : g_xbar
		localparam int LP = chan_route_pkg::LANE_PICK_TOP - 2 * i;
		localparam int OP = chan_route_pkg::OUT_PICK_TOP - 2 * i;
		assign laneWords.word[i] = fifoWords.word[xbar_reg[LP-:2]]; // R1
		assign routedWords.word[i] = laneWords.word[xbar_reg[OP-:2]]; // R2
	end

	assign loadOut = fifoValid && (!outValid_reg || outReady);
	assign outValid = outValid_reg;
	assign outWords = outWords_reg;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			outValid_reg <= 1'b0;
			outWords_reg <= '0;
		end else if (ce) begin
			if (loadOut) begin
				outWords_reg <= routedWords;
				outValid_reg <= 1'b1;
			end else if (outReady) begin
				outValid_reg <= 1'b0;
			end
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	sequence apbFirst;
		ce && psel && penable && !ready_reg;
	endsequence
	sequence apbDone;
		psel && penable && ready_reg;
	endsequence

	a_xbar_write_lands: assert property ( // R1
		wrAcc && selXbar && pstrb[1:0] == 2'b11
		|=> xbar_reg == $past(pwdata[15:0]))
		else $error("crossbar write not stored");

	a_output_a_route: assert property ( // R2
		ce && loadOut |=> outWords_reg.word[0] ==
		$past(fifoWords.word[xbar_reg[15 - 2 * xbar_reg[7:6] -: 2]]))
		else $error("output a routed from wrong word");

	a_pin_sleep_gate: assert property ( // R3
		ce && sleepLevel_reg && sleepRoute_reg[15]
		|=> powerDown[chan_route_pkg::SLP_CONV_A])
		else $error("converter a not asleep with pin high");

	a_sleep_released: assert property ( // R3
		ce && !sleepLevel_reg && swPd_reg == 16'h0000
		|=> powerDown == 16'h0000)
		else $error("power down without a cause");

	a_reserved_sleep_bit: assert property ( // R4
		powerDown[chan_route_pkg::SLP_RSVD] == 1'b0 &&
		powerDown[4:0] == 5'h00)
		else $error("unused sleep bit drives power down");

	a_software_sleep: assert property ( // R5
		ce && swPd_reg[chan_route_pkg::SLP_CONV_A]
		|=> powerDown[chan_route_pkg::SLP_CONV_A])
		else $error("software sleep ignored");

	a_data_delay_set: assert property ( // R6
		wrAcc && selDelay && pstrb[1] |=> dataDelay == $past(pwdata[15:13]))
		else $error("data delay not updated");

	a_clock_delay_set: assert property ( // R7
		wrAcc && selDelay && pstrb[1] |=> clockDelay == $past(pwdata[12:10]))
		else $error("clock delay not updated");

	a_reserved_reads_zero: assert property ( // R8
		(apbFirst and (selRsvd && !pwrite)) ##1 apbDone |-> prdata == 32'h0)
		else $error("reserved register reads nonzero");

	a_pin_filter_hold: assert property ( // R3
		ce && sleepSync_reg[1] != sleepSync_reg[2] |=> $stable(sleepLevel_reg))
		else $error("sleep level moved on disagreement");
endmodule

// ### verification/channel_routing_sleep_regs_tb.sv
/*
 * self-checking bench for the routing, sleep and delay register block.
 * assumes the apb slave answers with pready and that the word fifo
 * refuses with inReady low once it and the output stage are full.
 */
`timescale 1ns/10ps

module channel_routing_sleep_regs_tb;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'h3;
	logic pready, pslverr, inReady, outValid, err;
	logic inValid = 1'b0;
	logic outReady = 1'b0;
	logic sleepPin = 1'b0;
	logic [31:0] prdata, rd;
	logic [15:0] powerDown;
	logic [2:0] dataDelay, clockDelay;
	chan_route_pkg::quad_t inWords = '0;
	chan_route_pkg::quad_t outWords;
	int miscompares = 0;
	int checks_done = 0;

	channel_routing_sleep_regs #(
		.FIFO_DEPTH(16)
	) channel_routing_sleep_regs_i (
		.sys_clk(sys_clk), .rst(rst), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.inValid(inValid), .inReady(inReady), .inWords(inWords),
		.outValid(outValid), .outReady(outReady), .outWords(outWords),
		.sleepPin(sleepPin), .powerDown(powerDown), .dataDelay(dataDelay),
		.clockDelay(clockDelay));

	task results;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task check(input string name, input logic [63:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task timeout(input string name);
		miscompares++;
		$display("unexpected %s expected answer seen none", name);
		results();
	endtask

	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge sys_clk);
			if (pready === 1'b1)
				break;
		end
		if (n == 50)
			timeout("apb");
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	function automatic chan_route_pkg::quad_t mk(input int k);
		chan_route_pkg::quad_t w;
		for (int i = 0; i < 4; i++)
			w.word[i] = {8'(k), 8'(i)};
		return w;
	endfunction

	// output o takes lane pick L, lane L takes input word pick
	function automatic chan_route_pkg::quad_t route(input int k,
			input logic [15:0] x);
		chan_route_pkg::quad_t w;
		chan_route_pkg::quad_t r;
		logic [1:0] lane;
		w = mk(k);
		for (int o = 0; o < 4; o++) begin
			lane = x[7-2*o -: 2];
			r.word[o] = w.word[x[15-2*lane -: 2]];
		end
		return r;
	endfunction

	task regDefaults;
		apb(1'b0, 12'h088, 32'h0);
		check("crossbar", rd, 32'h1b1b);
		check("mapped err", err, 1'b0);
		apb(1'b0, 12'h08c, 32'h0);
		check("sleep route", rd, 32'hffff);
		apb(1'b0, 12'h090, 32'h0);
		check("delay", rd, 32'h0);
		check("delay outs", {dataDelay, clockDelay}, 6'h00);
		apb(1'b1, 12'h084, 32'h0);
		apb(1'b0, 12'h084, 32'h0);
		check("reserved", rd, 32'h0);
		apb(1'b0, 12'h200, 32'h0);
		check("unmapped err", err, 1'b1);
		check("unmapped data", rd, 32'h0);
	endtask

	task delays;
		apb(1'b1, 12'h090, 32'hfc00);
		apb(1'b0, 12'h090, 32'h0);
		check("delay", rd, 32'hfc00);
		check("data delay", dataDelay, 3'h7);
		check("clock delay", clockDelay, 3'h7);
		apb(1'b1, 12'h090, 32'h3400);
		apb(1'b0, 12'h090, 32'h0);
		check("data delay", dataDelay, 3'h1);
		check("clock delay", clockDelay, 3'h5);
	endtask

	// fill with the consumer stalled, then drain and compare in order
	task stream(input logic [15:0] x);
		int k, j, n;
		apb(1'b1, 12'h088, {16'h0, x});
		inValid <= 1'b1;
		inWords <= mk(0);
		k = 0;
		for (n = 0; n < 40; n++) begin
			@(posedge sys_clk);
			if (inReady !== 1'b1)
				break;
			k++;
			inWords <= mk(k);
		end
		if (n == 40)
			timeout("fill");
		inValid <= 1'b0;
		check("accepted", k, 17);
		outReady <= 1'b1;
		j = 0;
		for (n = 0; n < 100 && j < k; n++) begin
			@(posedge sys_clk);
			if (outValid === 1'b1) begin
				check("outWords", outWords, route(j, x));
				j++;
			end
		end
		if (j < k)
			timeout("drain");
		@(posedge sys_clk);
		check("outValid idle", outValid, 1'b0);
		outReady <= 1'b0;
	endtask

	task waitPd(input logic [15:0] exp);
		int n;
		for (n = 0; n < 20; n++) begin
			@(posedge sys_clk);
			if (powerDown === exp)
				break;
		end
		if (n == 20)
			timeout("powerDown");
		check("powerDown", powerDown, exp);
	endtask

	// clock enable low freezes the pin filter and power down
	task ceFreeze;
		ce <= 1'b0;
		sleepPin <= 1'b1;
		repeat (10) @(posedge sys_clk);
		check("frozen powerDown", powerDown, 16'h0000);
		ce <= 1'b1;
		waitPd(16'h0200);
		sleepPin <= 1'b0;
		waitPd(16'h0000);
	endtask

	task sleepGating;
		sleepPin <= 1'b1;
		waitPd(16'hffa0);
		apb(1'b1, 12'h08c, 32'h0240);
		waitPd(16'h0200);
		apb(1'b0, 12'h08c, 32'h0);
		check("sleep route", rd, 32'h0240);
		sleepPin <= 1'b0;
		waitPd(16'h0000);
		apb(1'b1, 12'h0fc, 32'h8020);
		waitPd(16'h8020);
		sleepPin <= 1'b1;
		waitPd(16'h8220);
		sleepPin <= 1'b0;
		apb(1'b1, 12'h0fc, 32'h0);
		waitPd(16'h0000);
	endtask

	initial begin
		forever #10 sys_clk = ~sys_clk;
	end

	initial begin
		repeat (8) @(posedge sys_clk);
		rst <= 1'b0;
		check("powerDown", powerDown, 16'h0);
		check("inReady", inReady, 1'b1);
		regDefaults();
		delays();
		stream(16'h1b1b);
		stream(16'h8dd2);
		sleepGating();
		ceFreeze();
		results();
	end
endmodule
